/* serial_channel_option_glue.v */
// Overview of operation
// - Two identical routing and driver-enable channels, each configured on its own.
// - Base codes 0-7 map to 3F8,2F8,3220,3228,4220,4228,5220,5228.
// - Base codes 8-15 map to 83F8,82F8,B220,B228,C220,C228,D220,D228.
// - Irq select 00,01,10,11 routes to request lines 3,4,7,9.
// - RTS transmit option drives RTS onto the auxiliary output unless the transmit clock or loopback option is also set.
// - CTS comes from own RTS when defeated, else from auxiliary input when the CTS receive option is set; otherwise 0.
// - Receive clock from transmit rate clock, or auxiliary input if external.
// - Transmit clock option drives rate clock onto the auxiliary output unless the loopback option is also set.
// - Loopback option echoes auxiliary input onto auxiliary output.
// - Half duplex: driver follows DTR; full duplex: driver not gated.
// - Positive polarity: DTR 1 enables drivers, starts disabled.
// - Inverted polarity: DTR 0 enables drivers, starts enabled.
// - Each channel decodes eight addresses on an eight-byte boundary, full 16 bits.
// - Interrupt reaches its line only while user output 2 is active.
`timescale 1ns/100ps
`include "glue_defines.vh"
module serial_channel_option_glue (
   input  wire        clk,            // 125 MHz clock
   input  wire        rst_n,          // Async reset, active low
   input  wire [3:0]  s_axi_awaddr,   // Write address
   input  wire        s_axi_awvalid,  // Write address valid
   output wire        s_axi_awready,  // Write address ready
   input  wire [31:0] s_axi_wdata,    // Write data
   input  wire [3:0]  s_axi_wstrb,    // Write strobes
   input  wire        s_axi_wvalid,   // Write data valid
   output wire        s_axi_wready,   // Write data ready
   output reg  [1:0]  s_axi_bresp,    // Write response
   output reg         s_axi_bvalid,   // Write response valid
   input  wire        s_axi_bready,   // Write response ready
   input  wire [3:0]  s_axi_araddr,   // Read address
   input  wire        s_axi_arvalid,  // Read address valid
   output wire        s_axi_arready,  // Read address ready
   output reg  [31:0] s_axi_rdata,    // Read data
   output reg  [1:0]  s_axi_rresp,    // Read response
   output reg         s_axi_rvalid,   // Read valid
   input  wire        s_axi_rready,   // Read ready
   input  wire [15:0] io_addr,        // Host I/O address
   input  wire [1:0]  rts,            // UART RTS per channel
   input  wire [1:0]  dtr,            // UART DTR per channel
   input  wire [1:0]  out2,           // UART user output 2
   input  wire [1:0]  uart_irq,       // UART interrupt
   input  wire [1:0]  rate_clk,       // UART transmit rate clock
   input  wire [1:0]  aux_in,         // Auxiliary input pairs
   output wire [1:0]  cts,            // To UART CTS
   output wire [1:0]  rclk,           // To UART receive clock
   output wire [1:0]  aux_out,        // Auxiliary output pairs
   output wire [1:0]  drv_en,         // Line driver enables
   output wire [1:0]  chan_sel,       // Channel selects
   output wire [2:0]  reg_sel,        // UART register select
   output wire [3:0]  irq_req         // Request lines 3,4,7,9
);
   // ---------------------------------------------------------------
   // Configuration registers
   // ---------------------------------------------------------------
   reg  [`CFG_W-1:0] cfg0_q;
   reg  [`CFG_W-1:0] cfg1_q;
   reg  [3:0]        awaddr_q;
   reg               aw_held_q;
   reg  [31:0]       wdata_q;
   reg  [3:0]        wstrb_q;
   reg               w_held_q;
   wire [7:0]        irq_all;
   wire [5:0]        rsel_all;

   assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
   assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;

   wire        aw_now = aw_held_q | (s_axi_awvalid & s_axi_awready);
   wire        w_now  = w_held_q | (s_axi_wvalid & s_axi_wready);
   wire [3:0]  wa     = aw_held_q ? awaddr_q : s_axi_awaddr;
   wire [31:0] wd     = w_held_q ? wdata_q : s_axi_wdata;
   wire [3:0]  ws     = w_held_q ? wstrb_q : s_axi_wstrb;
   wire        do_wr  = aw_now & w_now & !s_axi_bvalid;

   function [`CFG_W-1:0] merge;
      input [`CFG_W-1:0] old;
      input [31:0]       d;
      input [3:0]        s;
      begin
         merge = old;
         if (s[0])
            merge[7:0] = d[7:0];
         if (s[1])
            merge[`CFG_W-1:8] = d[`CFG_W-1:8];
      end
   endfunction

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg0_q       <= `CFG0_RST;
         cfg1_q       <= `CFG1_RST;
         awaddr_q     <= 4'h0;
         aw_held_q    <= 1'b0;
         wdata_q      <= 32'h0000_0000;
         wstrb_q      <= 4'h0;
         w_held_q     <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready && !do_wr) begin
            awaddr_q  <= s_axi_awaddr;
            aw_held_q <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready && !do_wr) begin
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
            w_held_q <= 1'b1;
         end
         if (do_wr) begin
            aw_held_q    <= 1'b0;
            w_held_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= `RESP_OKAY;
            case (wa)
               `REG_CFG0: cfg0_q <= merge(cfg0_q, wd, ws);
               `REG_CFG1: cfg1_q <= merge(cfg1_q, wd, ws);
               `REG_STATUS: s_axi_bresp <= `RESP_OKAY;
               default:   s_axi_bresp <= `RESP_SLVERR;
            endcase
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Read channel
   // ---------------------------------------------------------------
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= `RESP_OKAY;
         case (s_axi_araddr)
            `REG_CFG0:   s_axi_rdata <= {17'h0, cfg0_q};
            `REG_CFG1:   s_axi_rdata <= {17'h0, cfg1_q};
            `REG_STATUS: s_axi_rdata <= {20'h00000, irq_req, drv_en, aux_out, cts, chan_sel};
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= `RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Channels
   // ---------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : g_chan
         chan_route chan_route_inst (
            .cfg       ((g == 0) ? cfg0_q : cfg1_q),
            .io_addr   (io_addr),
            .rts       (rts[g]),
            .dtr       (dtr[g]),
            .out2      (out2[g]),
            .uart_irq  (uart_irq[g]),
            .rate_clk  (rate_clk[g]),
            .aux_in    (aux_in[g]),
            .cts       (cts[g]),
            .rclk      (rclk[g]),
            .aux_out   (aux_out[g]),
            .drv_en    (drv_en[g]),
            .chan_sel  (chan_sel[g]),
            .reg_sel   (rsel_all[3*g +: 3]),
            .irq_lines (irq_all[4*g +: 4])
         );
      end
   endgenerate
   // Shared request lines when both channels pick one
   assign irq_req = irq_all[3:0] | irq_all[7:4];
   assign reg_sel = rsel_all[2:0] | rsel_all[5:3];
endmodule

/* glue_defines.vh */
`ifndef GLUE_DEFINES_VH
`define GLUE_DEFINES_VH
// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define REG_CFG0        4'h0
`define REG_CFG1        4'h4
`define REG_STATUS      4'h8
// ---------------------------------------------------------------
// Config field positions
// ---------------------------------------------------------------
`define F_BASE_LO       0
`define F_IRQ_LO        4
`define F_EN            6
`define F_RTS_TX        7
`define F_CTS_RX        8
`define F_HS_DEFEAT     9
`define F_RCLK_EXT      10
`define F_TRANSMIT_RATE_CLOCK_TX       11
`define F_AUX_LOOP      12
`define F_HALF_DUPLEX   13
`define F_DTR_INV       14
`define CFG_W           15
// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define CFG0_RST        15'h0180
`define CFG1_RST        15'h0181
// ---------------------------------------------------------------
// AXI responses
// ---------------------------------------------------------------
`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10
`endif

/* chan_route.v */
`timescale 1ns/100ps
`include "glue_defines.vh"
module chan_route (
   input  wire [`CFG_W-1:0] cfg,          // Channel configuration
   input  wire [15:0]       io_addr,      // Host I/O address
   input  wire              rts,          // UART request to send
   input  wire              dtr,          // UART terminal ready
   input  wire              out2,         // UART user output 2
   input  wire              uart_irq,     // UART interrupt
   input  wire              rate_clk,     // Transmit rate clock
   input  wire              aux_in,       // Auxiliary input pair
   output reg               cts,          // To UART clear to send
   output reg               rclk,         // To UART receive clock
   output reg               aux_out,      // Auxiliary output pair
   output wire              drv_en,       // Line driver enable
   output wire              chan_sel,     // Channel selected
   output wire [2:0]        reg_sel,      // UART register select
   output reg  [3:0]        irq_lines     // IRQ 3,4,7,9 requests
);
   reg [15:0] base;
   wire [3:0] bsel = cfg[`F_BASE_LO+3:`F_BASE_LO];
   wire       dtr_lvl = dtr ^ cfg[`F_DTR_INV];
   wire       irq_g = uart_irq & out2;
   always @* begin
      case (bsel[2:0])
         3'h0: base = 16'h03f8;
         3'h1: base = 16'h02f8;
         3'h2: base = 16'h3220;
         3'h3: base = 16'h3228;
         3'h4: base = 16'h4220;
         3'h5: base = 16'h4228;
         3'h6: base = 16'h5220;
         default: base = 16'h5228;
      endcase
      if (bsel[3] && bsel[2:1] != 2'b00)
         base = base + 16'h8000;
      else if (bsel[3])
         base = base | 16'h8000;
      case (cfg[`F_IRQ_LO+1:`F_IRQ_LO])
         2'b00:   irq_lines = {3'b000, irq_g};
         2'b01:   irq_lines = {2'b00, irq_g, 1'b0};
         2'b10:   irq_lines = {1'b0, irq_g, 2'b00};
         default: irq_lines = {irq_g, 3'b000};
      endcase
      if (cfg[`F_HS_DEFEAT])
         cts = rts;
      else if (cfg[`F_CTS_RX])
         cts = aux_in;
      else
         cts = 1'b0;
      rclk = cfg[`F_RCLK_EXT] ? aux_in : rate_clk;
      if (cfg[`F_AUX_LOOP])
         aux_out = aux_in;
      else if (cfg[`F_TRANSMIT_RATE_CLOCK_TX])
         aux_out = rate_clk;
      else if (cfg[`F_RTS_TX])
         aux_out = rts;
      else
         aux_out = 1'b0;
   end
   assign drv_en   = cfg[`F_HALF_DUPLEX] ? dtr_lvl : 1'b1;
   assign chan_sel = cfg[`F_EN] && (io_addr[15:3] == base[15:3]);
   assign reg_sel  = io_addr[2:0];
endmodule

/* glue_chk.sv */
`timescale 1ns/100ps
module glue_chk (
   input wire        clk,           // Clock
   input wire        rst_n,         // Reset, active low
   input wire        s_axi_awvalid, // Write address valid
   input wire        s_axi_awready, // Write address ready
   input wire        s_axi_wvalid,  // Write data valid
   input wire        s_axi_wready,  // Write data ready
   input wire        s_axi_bvalid,  // Write response valid
   input wire        s_axi_bready,  // Write response ready
   input wire        s_axi_arvalid, // Read address valid
   input wire        s_axi_arready, // Read address ready
   input wire        s_axi_rvalid,  // Read valid
   input wire        s_axi_rready,  // Read ready
   input wire [15:0] io_addr,       // Host address
   input wire [1:0]  out2,          // User output 2
   input wire [1:0]  uart_irq,      // UART interrupts
   input wire [1:0]  chan_sel,      // Channel selects
   input wire [2:0]  reg_sel,       // Register select
   input wire [3:0]  irq_req        // Request lines
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   reg_pass_a: assert property (reg_sel == io_addr[2:0])
      else $error("register select differs from address");
   irq_gate_a: assert property (irq_req != 4'h0 |-> (uart_irq & out2) != 2'h0)
      else $error("request without gated interrupt");
   base_dec_a: assert property (chan_sel != 2'h0 |-> {io_addr[15:3], 3'h0} inside
      {16'h3f8, 16'h2f8, 16'h3220, 16'h3228, 16'h4220, 16'h4228, 16'h5220, 16'h5228,
       16'h83f8, 16'h82f8, 16'hb220, 16'hb228, 16'hc220, 16'hc228, 16'hd220, 16'hd228})
      else $error("select outside base list");
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped early");
   rresp_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rvalid))
      else $error("read response dropped early");
   wresp_due_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> s_axi_bvalid) else $error("write response late");
   rresp_due_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read response late");
   read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answer pending");
   write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while answer pending");
   bresp_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
endmodule
bind serial_channel_option_glue glue_chk glue_chk_inst (.*);

/* link_peer.sv */
`timescale 1ns/100ps
module link_peer (
   input  wire  [1:0] pat,     // Level the peer sends
   input  wire  [1:0] aux_out, // Auxiliary output seen
   output logic [1:0] aux_in   // Auxiliary input pairs
);
   assign aux_in = pat;
endmodule

/* serial_channel_option_glue_tb.sv */
`timescale 1ns/100ps
`include "glue_defines.vh"
module serial_channel_option_glue_tb;
   logic        clk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
   logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb, irq_req;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rts, dtr, out2, uart_irq, rate_clk;
   logic [1:0]  pat, aux_in, cts, rclk, aux_out, drv_en, chan_sel;
   logic [15:0] io_addr;
   logic [2:0]  reg_sel;
   int          bad_count = 0, total_checks = 0, cyc = 0;
   // Config, inputs rts/clk/aux/dtr, outputs cts/rclk/aux_out/drv_en
   logic [23:0] rows [14] = '{24'h018083, 24'h01806d, 24'h02808b, 24'h038021,
      24'h040025, 24'h088047, 24'h088081, 24'h188023, 24'h1880c5, 24'h200011,
      24'h200000, 24'h600001, 24'h600010, 24'h400011};
   logic [15:0] bases [16] = '{16'h3f8, 16'h2f8, 16'h3220, 16'h3228, 16'h4220,
      16'h4228, 16'h5220, 16'h5228, 16'h83f8, 16'h82f8, 16'hb220, 16'hb228,
      16'hc220, 16'hc228, 16'hd220, 16'hd228};
   serial_channel_option_glue serial_channel_option_glue_inst (.*);
   link_peer link_peer_inst (.*);
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task chk(input [31:0] s, input [31:0] e);
      total_checks++;
      if (s !== e) begin
         bad_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task print_verdict;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task axw(input [3:0] a, input [31:0] d, input [1:0] er);
      logic ad, wd;
      ad = 0;
      wd = 0;
      @(posedge clk);
      {s_axi_awaddr, s_axi_wdata} <= {a, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      while (!(ad && wd)) begin
         @(negedge clk);
         if (s_axi_awvalid && s_axi_awready) ad = 1;
         if (s_axi_wvalid && s_axi_wready) wd = 1;
         @(posedge clk);
         if (ad) s_axi_awvalid <= 0;
         if (wd) s_axi_wvalid <= 0;
      end
      do @(negedge clk); while (!s_axi_bvalid);
      chk(s_axi_bresp, er);
      @(posedge clk) s_axi_bready <= 0;
   endtask
   task axr(input [3:0] a, input [1:0] er);
      @(posedge clk);
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
      do @(negedge clk); while (!s_axi_arready);
      @(posedge clk) s_axi_arvalid <= 0;
      do @(negedge clk); while (!s_axi_rvalid);
      rd = s_axi_rdata;
      chk(s_axi_rresp, er);
      @(posedge clk) s_axi_rready <= 0;
   endtask
   // ----------------------------------------
   // Clock, timeout, sequence
   // ----------------------------------------
   initial begin
      clk = 0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         bad_count++;
         print_verdict;
      end
   end
   initial begin
      {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, io_addr} = 0;
      s_axi_wstrb = 4'hf;
      {rts, dtr, out2, uart_irq, rate_clk, pat} = 0;
      repeat (2) @(posedge clk);
      rst_n <= 1;
      axr(`REG_CFG0, `RESP_OKAY);
      chk(rd, 32'h180);
      axr(`REG_CFG1, `RESP_OKAY);
      chk(rd, 32'h181);
      axr(4'hc, `RESP_SLVERR);
      axw(4'hc, 32'h0, `RESP_SLVERR);
      $display("bus test done");
      foreach (rows[i]) begin
         axw(`REG_CFG0, rows[i][23:8], `RESP_OKAY);
         @(posedge clk);
         {rts, rate_clk} <= {~rows[i][7], rows[i][7], ~rows[i][6], rows[i][6]};
         {pat, dtr} <= {~rows[i][5], rows[i][5], ~rows[i][4], rows[i][4]};
         @(negedge clk);
         chk({cts[0], rclk[0], aux_out[0], drv_en[0]}, rows[i][3:0]);
         chk({cts[1], rclk[1], aux_out[1], drv_en[1]}, {~rows[i][5], ~rows[i][6], ~rows[i][7], 1'b1});
      end
      $display("routing test done");
      for (int i = 0; i < 16; i++) begin
         axw(`REG_CFG0, 32'h40 | i, `RESP_OKAY);
         @(posedge clk) io_addr <= bases[i] | 16'h5;
         @(negedge clk) chk(chan_sel[0], 1);
         chk(reg_sel, 3'h5);
         @(posedge clk) io_addr <= bases[i] ^ 16'h8;
         @(negedge clk) chk(chan_sel[0], 0);
         axw(`REG_CFG0, i, `RESP_OKAY);
         @(posedge clk) io_addr <= bases[i];
         @(negedge clk) chk(chan_sel[0], 0);
      end
      axw(`REG_CFG1, 32'h41, `RESP_OKAY);
      @(posedge clk) io_addr <= 16'h2fc;
      @(negedge clk) chk(chan_sel[1], 1);
      $display("decode test done");
      for (int j = 0; j < 4; j++) begin
         axw(`REG_CFG0, 32'h40 | (j << 4), `RESP_OKAY);
         @(posedge clk) {uart_irq, out2} <= 4'h5;
         @(negedge clk) chk(irq_req, 1 << j);
         @(posedge clk) out2 <= 2'h0;
         @(negedge clk) chk(irq_req, 0);
      end
      @(posedge clk) {uart_irq, out2} <= 4'ha;
      @(negedge clk) chk(irq_req, 1);
      $display("interrupt test done");
      axw(`REG_STATUS, 32'h0, `RESP_OKAY);
      axr(`REG_STATUS, `RESP_OKAY);
      chk(rd, 32'h1c2);
      $display("status test done");
      print_verdict;
   end
endmodule
